// *** bench/cmp_sel_props.sv ***
// Assertion checker for the comparator input select block
`timescale 1ns/1ps
`include "cmp_select_defines.vh"
module cmp_sel_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [`NEG_W-1:0] cmp0_neg_en,
  input wire [`POS_W-1:0] cmp0_pos_en,
  input wire cmp0_half_div_en,
  input wire [`NEG_W-1:0] cmp1_neg_en,
  input wire [`POS_W-1:0] cmp1_pos_en,
  input wire cmp1_half_div_en
);
  wire acc = psel && penable;
  wire hit = paddr[1:0] == 2'h0 && paddr[11:2] inside
    {`CMP1_SEL_IDX, `CMP0_SEL_IDX, `STATUS_IDX, `CTRL_IDX};
  reg [2:0] idle_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_q <= 3'h0;
    else if (acc && pwrite) idle_q <= 3'h0;
    else if (idle_q != 3'h7) idle_q <= idle_q + 3'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (pslverr == (acc && !hit))
    else $error("pslverr wrong");
  a_read_byte: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_half_link0: assert property (cmp0_half_div_en ==
    (cmp0_neg_en[`NEG_HALF_BIT] || cmp0_pos_en[`POS_HALF_BIT]))
    else $error("divider 0 wrong");
  a_half_link1: assert property (cmp1_half_div_en ==
    (cmp1_neg_en[`NEG_HALF_BIT] || cmp1_pos_en[`POS_HALF_BIT]))
    else $error("divider 1 wrong");
  a_reset_sel: assert property ($rose(presetn) |->
    cmp0_neg_en == `NEG_SEL_RST && cmp0_pos_en == `POS_SEL_RST &&
    cmp1_neg_en == `NEG_SEL_RST && cmp1_pos_en == `POS_SEL_RST)
    else $error("reset select wrong");
  a_onehot_sel: assert property ($onehot0(cmp0_neg_en) &&
    $onehot0(cmp0_pos_en) && $onehot0(cmp1_neg_en) && $onehot0(cmp1_pos_en))
    else $error("select not one-hot");
  a_hold_idle: assert property (idle_q >= 3'h5 |->
    $stable(cmp0_neg_en) && $stable(cmp0_pos_en) &&
    $stable(cmp1_neg_en) && $stable(cmp1_pos_en))
    else $error("select moved without write");
  c_wr0: cover property (acc && pwrite && paddr == 12'h27C);
  c_err: cover property (pslverr);
  c_half: cover property (cmp0_half_div_en && cmp1_half_div_en);
  c_status: cover property (acc && !pwrite && paddr == 12'h280);
endmodule // cmp_sel_props

// *** bench/comparator_input_select_regs_tb.sv ***
// Testbench for the comparator input select block
`timescale 1ns/1ps
`include "cmp_select_defines.vh"
module comparator_input_select_regs_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] pstrb = 0;
  wire [31:0] prdata;
  wire pready, pslverr, h0, h1;
  wire [10:0] n0, n1;
  wire [11:0] p0, p1;
  integer errors = 0, num_checks = 0, cyc = 0, i;
  localparam A1 = 12'h278, A0 = 12'h27C, AS = 12'h280, AC = 12'h284;
  comparator_input_select_regs uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp0_neg_en(n0), .cmp0_pos_en(p0),
    .cmp0_half_div_en(h0), .cmp1_neg_en(n1), .cmp1_pos_en(p1),
    .cmp1_half_div_en(h1));
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("Error %0s exp %h got %h", nm, e, g);
    end
  endtask
  task xf(input w, input [11:0] a, input [7:0] d, input [3:0] s,
          input [7:0] e, input er);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
    pwdata <= {24'h0, d}; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) chk("rdata", {24'h0, e}, prdata);
    chk("slverr", {31'h0, er}, {31'h0, pslverr});
    psel <= 0; penable <= 0;
  endtask
  function [10:0] ne(input [3:0] c);
    ne = c <= 6 ? 11'h1 << c : c >= 4'hC ? 11'h080 << (c - 4'hC) : 11'h0;
  endfunction
  function [11:0] pe(input [3:0] c);
    pe = c <= 7 ? 12'h1 << c : c >= 4'hC ? 12'h100 << (c - 4'hC) : 12'h0;
  endfunction
  task ens(input [7:0] b0, input [7:0] b1);
    chk("en0", {ne(b0[7:4]), pe(b0[3:0]), b0[7:4] == 4'hD || b0[3:0] == 4'hD},
        {n0, p0, h0});
    chk("en1", {ne(b1[7:4]), pe(b1[3:0]), b1[7:4] == 4'hD || b1[3:0] == 4'hD},
        {n1, p1, h1});
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    xf(0, A0, 0, 0, 8'hFF, 0);
    xf(0, A1, 0, 0, 8'hFF, 0);
    ens(8'hFF, 8'hFF);
    for (i = 0; i < 16; i = i + 1) begin
      xf(1, A0, {i[3:0], i[3:0]}, 4'h1, 0, 0);
      xf(1, A1, ~{i[3:0], i[3:0]}, 4'h1, 0, 0);
      repeat (6) @(posedge pclk);
      ens({i[3:0], i[3:0]}, ~{i[3:0], i[3:0]});
      xf(0, A0, 0, 0, {i[3:0], i[3:0]}, 0);
      xf(0, A1, 0, 0, ~{i[3:0], i[3:0]}, 0);
    end
    xf(1, A0, 8'h3D, 4'h1, 0, 0);
    xf(1, A1, 8'hD3, 4'h1, 0, 0);
    repeat (6) @(posedge pclk);
    ens(8'h3D, 8'hD3);
    xf(1, A0, 8'h5A, 4'h0, 0, 0);
    xf(0, A0, 0, 0, 8'h3D, 0);
    xf(1, 12'h000, 8'h12, 4'h1, 0, 1);
    xf(0, 12'h000, 0, 0, 8'h00, 1);
    xf(1, A0, 8'h01, 4'h1, 0, 0);
    @(posedge pclk);
    #1 chk("gap", 0, {n0, p0, h0});
    repeat (3) @(posedge pclk);
    #1 ens(8'h01, 8'hD3);
    xf(0, AS, 0, 0, 8'h08, 0);
    xf(0, AC, 0, 0, 8'h01, 0);
    xf(1, AC, 8'h00, 4'h1, 0, 0);
    xf(0, AC, 0, 0, 8'h00, 0);
    xf(1, A1, 8'h77, 4'h1, 0, 0);
    @(posedge pclk);
    #1 ens(8'h01, 8'hD3);
    @(posedge pclk);
    #1 ens(8'h01, 8'h77);
    xf(0, AS, 0, 0, 8'h20, 0);
    end_sim;
  end
endmodule // comparator_input_select_regs_tb
bind comparator_input_select_regs cmp_sel_props chk (.*);

// *** hw/cmp_select_defines.vh ***
// Constants for the comparator input select registers
`ifndef CMP_SELECT_DEFINES_VH
`define CMP_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Register map (index; byte address is index times four)
// ----------------------------------------------------------------
`define SEL_PAGE 4'h0
`define CMP1_SEL_IDX 10'h09E
`define CMP0_SEL_IDX 10'h09F
`define STATUS_IDX 10'h0A0
`define CTRL_IDX 10'h0A1
`define ADDR_W 12
`define IDX_W 10

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define NEG_MSB 7
`define NEG_LSB 4
`define POS_MSB 3
`define POS_LSB 0
`define SEL_RESET 8'hFF
`define CTRL_RESET 8'h01
`define CTRL_BBM_BIT 0
`define STATUS_SETTLE_LSB 0
`define STATUS_HALF_LSB 2
`define STATUS_RSVD_LSB 4

// ----------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------
`define NEG_PIN_MAX 4'h6
`define POS_PIN_MAX 4'h7
`define CODE_TOUCH 4'hC
`define CODE_HALF 4'hD
`define CODE_SUPPLY 4'hE
`define CODE_TOP 4'hF

// ----------------------------------------------------------------
// One-hot enable layout
// ----------------------------------------------------------------
`define NEG_W 11
`define POS_W 12
`define NEG_TOUCH_BIT 7
`define NEG_HALF_BIT 8
`define NEG_DSUP_BIT 9
`define NEG_GND_BIT 10
`define POS_TOUCH_BIT 8
`define POS_HALF_BIT 9
`define POS_VBAT_BIT 10
`define POS_VDD_BIT 11
`define NEG_SEL_RST 11'h400
`define POS_SEL_RST 12'h800

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BBM_CYCLES 2'h2
`define BBM_W 2

`endif

// *** hw/comparator_input_select_regs.v ***
// Comparator input select registers with APB access and mux enables
//
// Notes on behaviour
// - Comparator 0 byte: upper nibble negative code, lower positive, all RW.
// - Comparator 1 byte has the same layout and code maps, all RW.
// - Comparator 0 byte sits at index 0x9F, page 0, resets to 0xFF.
// - Comparator 1 byte sits at index 0x9E, page 0, resets to 0xFF.
// - Code 1101 in either field picks half supply; only then divider on.
`timescale 1ns/1ps
`include "cmp_select_defines.vh"

module comparator_input_select_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [`NEG_W-1:0] cmp0_neg_en,
  output wire [`POS_W-1:0] cmp0_pos_en,
  output wire cmp0_half_div_en,
  output wire [`NEG_W-1:0] cmp1_neg_en,
  output wire [`POS_W-1:0] cmp1_pos_en,
  output wire cmp1_half_div_en
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam [1:0] HIT_NONE = 2'h0;
  localparam [1:0] HIT_SEL = 2'h1;
  localparam [1:0] HIT_STATUS = 2'h2;
  localparam [1:0] HIT_CTRL = 2'h3;

  function [1:0] addr_kind;
    input [`ADDR_W-1:0] a;
    begin
      if (a == {`CMP0_SEL_IDX, 2'b00} || a == {`CMP1_SEL_IDX, 2'b00}) begin
        addr_kind = HIT_SEL;
      end else if (a == {`STATUS_IDX, 2'b00}) begin
        addr_kind = HIT_STATUS;
      end else if (a == {`CTRL_IDX, 2'b00}) begin
        addr_kind = HIT_CTRL;
      end else begin
        addr_kind = HIT_NONE;
      end
    end
  endfunction

  function sel_slot;
    input [`ADDR_W-1:0] a;
    begin
      sel_slot = (a == {`CMP1_SEL_IDX, 2'b00});
    end
  endfunction

  wire [1:0] kind;
  wire setup_phase;
  wire access_phase;
  wire wr_en;

  assign kind = addr_kind(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en = access_phase & pwrite & pstrb[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] sel_q [0:1];
  reg [7:0] ctrl_q;
  reg [31:0] prdata_q;
  wire [7:0] status;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q[0] <= `SEL_RESET;
      sel_q[1] <= `SEL_RESET;
    end else if (wr_en && kind == HIT_SEL) begin
      // Whole byte writable, both nibbles
      sel_q[sel_slot(paddr)] <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_en && kind == HIT_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      case (kind)
        HIT_SEL: prdata_q <= {24'h000000, sel_q[sel_slot(paddr)]};
        HIT_STATUS: prdata_q <= {24'h000000, status};
        HIT_CTRL: prdata_q <= {24'h000000, ctrl_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access_phase & (kind == HIT_NONE);

  // ----------------------------------------------------------------
  // Per-comparator decode and break-before-make
  // ----------------------------------------------------------------
  wire [`NEG_W-1:0] neg_en [0:1];
  wire [`POS_W-1:0] pos_en [0:1];
  wire [1:0] half_en;
  wire [1:0] settling;
  wire [1:0] half_live;
  wire [1:0] rsvd;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_cmp
      reg [7:0] applied_q;
      reg [`BBM_W-1:0] gap_q;
      reg [`NEG_W-1:0] neg_q;
      reg [`POS_W-1:0] pos_q;
      reg half_q;
      wire [`NEG_W-1:0] neg_dec;
      wire [`POS_W-1:0] pos_dec;
      wire half_dec;
      wire rsvd_dec;
      wire changed;

      input_code_decoder u_dec (
        .sel_byte(applied_q),
        .neg_sel(neg_dec),
        .pos_sel(pos_dec),
        .half_div_en(half_dec),
        .reserved_code(rsvd_dec)
      );

      assign changed = (sel_q[i] != applied_q);

      // Open all switches for a short gap before a new selection
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          applied_q <= `SEL_RESET;
          gap_q <= {`BBM_W{1'b0}};
        end else if (changed) begin
          applied_q <= sel_q[i];
          gap_q <= ctrl_q[`CTRL_BBM_BIT] ? `BBM_CYCLES : {`BBM_W{1'b0}};
        end else if (gap_q != {`BBM_W{1'b0}}) begin
          gap_q <= gap_q - 1'b1;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          neg_q <= `NEG_SEL_RST;
          pos_q <= `POS_SEL_RST;
          half_q <= 1'b0;
        end else if (changed && ctrl_q[`CTRL_BBM_BIT]) begin
          neg_q <= {`NEG_W{1'b0}};
          pos_q <= {`POS_W{1'b0}};
          half_q <= 1'b0;
        end else if (gap_q == {`BBM_W{1'b0}}) begin
          neg_q <= neg_dec;
          pos_q <= pos_dec;
          half_q <= half_dec;
        end
      end

      assign neg_en[i] = neg_q;
      assign pos_en[i] = pos_q;
      assign half_en[i] = half_q;
      assign settling[i] = changed | (gap_q != {`BBM_W{1'b0}});
      assign half_live[i] = half_q;
      assign rsvd[i] = rsvd_dec;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and outputs
  // ----------------------------------------------------------------
  assign status = {2'b00, rsvd, half_live, settling};

  assign cmp0_neg_en = neg_en[0];
  assign cmp0_pos_en = pos_en[0];
  assign cmp0_half_div_en = half_en[0];
  assign cmp1_neg_en = neg_en[1];
  assign cmp1_pos_en = pos_en[1];
  assign cmp1_half_div_en = half_en[1];

endmodule // comparator_input_select_regs

// *** hw/input_code_decoder.v ***
// Decoder from a select byte to one-hot analog mux enables
`timescale 1ns/1ps
`include "cmp_select_defines.vh"

module input_code_decoder (
  input wire [7:0] sel_byte,
  output wire [`NEG_W-1:0] neg_sel,
  output wire [`POS_W-1:0] pos_sel,
  output wire half_div_en,
  output wire reserved_code
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function [`NEG_W-1:0] decode_neg;
    input [3:0] code;
    begin
      decode_neg = {`NEG_W{1'b0}};
      if (code <= `NEG_PIN_MAX) begin
        decode_neg[code] = 1'b1;
      end else begin
        case (code)
          `CODE_TOUCH: decode_neg[`NEG_TOUCH_BIT] = 1'b1;
          `CODE_HALF: decode_neg[`NEG_HALF_BIT] = 1'b1;
          `CODE_SUPPLY: decode_neg[`NEG_DSUP_BIT] = 1'b1;
          `CODE_TOP: decode_neg[`NEG_GND_BIT] = 1'b1;
          default: decode_neg = {`NEG_W{1'b0}};
        endcase
      end
    end
  endfunction

  function [`POS_W-1:0] decode_pos;
    input [3:0] code;
    begin
      decode_pos = {`POS_W{1'b0}};
      if (code <= `POS_PIN_MAX) begin
        decode_pos[code] = 1'b1;
      end else begin
        case (code)
          `CODE_TOUCH: decode_pos[`POS_TOUCH_BIT] = 1'b1;
          `CODE_HALF: decode_pos[`POS_HALF_BIT] = 1'b1;
          `CODE_SUPPLY: decode_pos[`POS_VBAT_BIT] = 1'b1;
          `CODE_TOP: decode_pos[`POS_VDD_BIT] = 1'b1;
          default: decode_pos = {`POS_W{1'b0}};
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign neg_sel = decode_neg(sel_byte[`NEG_MSB:`NEG_LSB]);
  assign pos_sel = decode_pos(sel_byte[`POS_MSB:`POS_LSB]);
  // Divider draws current only when a field picks it
  assign half_div_en = neg_sel[`NEG_HALF_BIT] |
                       pos_sel[`POS_HALF_BIT];
  assign reserved_code = ~(|neg_sel) | ~(|pos_sel);

endmodule // input_code_decoder
